// >>> pc_and_return_stack_unit.sv
// Program counter, hardware return stack and fast shadow stack with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module pc_and_return_stack_unit
    import pcstack_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Decoder and interrupt commands
    input wire logic CMD_VALID,
    input wire logic [3:0] CMD,
    input wire logic [20:0] TARGET,
    // Registers captured into the shadow
    input wire logic [7:0] STATUS_IN,
    input wire logic [7:0] WORK_IN,
    input wire logic [7:0] BANK_IN,
    // Core side results
    output logic [20:0] PC_OUT,
    output logic [3:0] PHASE,
    output logic STACK_RESET,
    output logic RESTORE_VALID,
    output logic [7:0] RESTORE_STATUS,
    output logic [7:0] RESTORE_WORK,
    output logic [7:0] RESTORE_BANK
);

    typedef struct packed {
        logic [30:0][20:0] stk;
        logic [4:0] sp;
        logic full;
        logic unf;
        logic opt;
        logic [20:0] pc;
        logic [7:0] lath;
        logic [4:0] latu;
        logic [3:0] phase;
        logic [7:0] sh_status;
        logic [7:0] sh_work;
        logic [7:0] sh_bank;
        logic rvalid;
        logic rst_out;
        logic pend;
        logic wr;
        logic [7:0] addr;
        logic ready;
        logic resp;
        logic [31:0] rdata;
    } state_s;

    state_s st_q;
    state_s st_d;
    cmd_e cmd;
    logic do_push;
    logic do_pop;
    logic do_ret;
    logic ld_tgt;
    logic fast_sh;
    logic fast_rs;
    logic pc_wr;
    logic [20:0] top_q;
    logic [20:0] top_n;

    // Word under the pointer, zero when empty
    function automatic logic [20:0] entry_at(input logic [30:0][20:0] s, input logic [4:0] p);
        entry_at = (p == SP_EMPTY) ? PC_RESET : s[p - SP_ONE];
    endfunction

    assign cmd = cmd_e'(CMD);
    assign top_q = entry_at(st_q.stk, st_q.sp);

    // Next state: bus access first, then command, then phase step
    always_comb begin
        st_d = st_q;
        top_n = PC_RESET;
        do_push = 1'b0;
        do_pop = 1'b0;
        do_ret = 1'b0;
        ld_tgt = 1'b0;
        fast_sh = 1'b0;
        fast_rs = 1'b0;
        pc_wr = 1'b0;
        st_d.rst_out = 1'b0;
        st_d.rvalid = 1'b0;
        // Bus data phase, one wait state
        if (st_q.pend) begin
            st_d.pend = 1'b0;
            st_d.ready = 1'b1;
            st_d.rdata = 32'h0;
            if (!st_q.wr) begin
                case (st_q.addr)
                    OFF_STACK_PTR: begin
                        st_d.rdata[FULL_BIT] = st_q.full;
                        st_d.rdata[UNF_BIT] = st_q.unf;
                        st_d.rdata[RSVD_BIT] = 1'b0;
                        st_d.rdata[4:0] = st_q.sp;
                    end
                    OFF_TOP_LOW: st_d.rdata[7:0] = top_q[7:0];
                    OFF_TOP_HIGH: st_d.rdata[7:0] = top_q[15:8];
                    OFF_TOP_UPPER: st_d.rdata[4:0] = top_q[20:16];
                    OFF_PC_LOW: begin
                        st_d.rdata[7:0] = st_q.pc[7:0];
                        st_d.lath = st_q.pc[15:8];
                        st_d.latu = st_q.pc[20:16];
                    end
                    OFF_PC_HIGH_LAT: st_d.rdata[7:0] = st_q.lath;
                    OFF_PC_UPPER_LAT: st_d.rdata[4:0] = st_q.latu;
                    OFF_CONTROL: st_d.rdata[OPT_BIT] = st_q.opt;
                    default: st_d.rdata = 32'h0;
                endcase
            end else begin
                case (st_q.addr)
                    OFF_STACK_PTR: begin
                        st_d.sp = HWDATA[4:0];
                        st_d.full = st_q.full & HWDATA[FULL_BIT];
                        st_d.unf = st_q.unf & HWDATA[UNF_BIT];
                    end
                    OFF_TOP_LOW: begin
                        if (st_q.sp != SP_EMPTY) begin
                            st_d.stk[st_q.sp - SP_ONE][7:0] = HWDATA[7:0];
                        end
                    end
                    OFF_TOP_HIGH: begin
                        if (st_q.sp != SP_EMPTY) begin
                            st_d.stk[st_q.sp - SP_ONE][15:8] = HWDATA[7:0];
                        end
                    end
                    OFF_TOP_UPPER: begin
                        if (st_q.sp != SP_EMPTY) begin
                            st_d.stk[st_q.sp - SP_ONE][20:16] = HWDATA[4:0];
                        end
                    end
                    OFF_PC_LOW: begin
                        st_d.pc = {st_q.latu, st_q.lath, HWDATA[7:1], 1'b0};
                        pc_wr = 1'b1;
                    end
                    OFF_PC_HIGH_LAT: st_d.lath = HWDATA[7:0];
                    OFF_PC_UPPER_LAT: st_d.latu = HWDATA[4:0];
                    OFF_CONTROL: st_d.opt = HWDATA[OPT_BIT];
                    default: st_d.opt = st_q.opt;
                endcase
            end
        end else if (HSEL && HTRANS[1] && HREADY) begin
            // Address phase taken; misaligned or high addresses go unmapped
            st_d.pend = 1'b1;
            st_d.ready = 1'b0;
            st_d.wr = HWRITE;
            st_d.addr = (HADDR[31:8] == 24'h0) ? HADDR[7:0] : OFF_UNMAPPED;
        end
        // Decode one command
        if (CMD_VALID) begin
            case (cmd)
                CMD_CALL: begin
                    do_push = 1'b1;
                    ld_tgt = 1'b1;
                end
                CMD_CALL_FAST: begin
                    do_push = 1'b1;
                    ld_tgt = 1'b1;
                    fast_sh = 1'b1;
                end
                CMD_INT_ACK: begin
                    do_push = 1'b1;
                    ld_tgt = 1'b1;
                    fast_sh = 1'b1;
                end
                CMD_RETURN, CMD_RET_LIT, CMD_RET_INT: begin
                    do_pop = 1'b1;
                    do_ret = 1'b1;
                end
                CMD_RETURN_FAST, CMD_RET_INT_FAST: begin
                    do_pop = 1'b1;
                    do_ret = 1'b1;
                    fast_rs = 1'b1;
                end
                CMD_PUSH: do_push = 1'b1;
                CMD_POP: do_pop = 1'b1;
                CMD_JUMP: ld_tgt = 1'b1;
                default: ld_tgt = 1'b0;
            endcase
        end
        top_n = entry_at(st_d.stk, st_d.sp);
        // Push uses the pointer as possibly just written by software
        if (do_push) begin
            if (st_d.sp == SP_TOP) begin
                st_d.full = 1'b1;
                st_d.rst_out = st_d.opt;
            end else if (st_d.sp == SP_LAST && st_d.opt) begin
                st_d.stk[SP_LAST] = st_d.pc + PC_STEP;
                st_d.full = 1'b1;
                st_d.rst_out = 1'b1;
            end else begin
                st_d.stk[st_d.sp] = st_d.pc;
                st_d.sp = st_d.sp + SP_ONE;
                if (st_d.sp == SP_TOP) begin
                    st_d.full = 1'b1;
                end
            end
        end
        // Pop: underflow at empty, else load the pc on returns and decrement
        if (do_pop) begin
            if (st_d.sp == SP_EMPTY) begin
                st_d.unf = 1'b1;
                st_d.rst_out = st_d.opt;
                if (do_ret) begin
                    st_d.pc = PC_RESET;
                end
            end else begin
                if (do_ret) begin
                    st_d.pc = top_n;
                end
                st_d.sp = st_d.sp - SP_ONE;
            end
        end
        // Direct load from the instruction, latches untouched
        if (ld_tgt) begin
            st_d.pc = {TARGET[20:1], 1'b0};
        end
        // Shadow capture and restore
        if (fast_sh) begin
            st_d.sh_status = STATUS_IN;
            st_d.sh_work = WORK_IN;
            st_d.sh_bank = BANK_IN;
        end
        st_d.rvalid = fast_rs;
        // Quadrature phase ring and sequential step in Q1
        st_d.phase = {st_q.phase[2:0], st_q.phase[3]};
        if (!do_push && !do_pop && !ld_tgt && !pc_wr && st_q.phase == PHASE_Q1) begin
            st_d.pc = st_d.pc + PC_STEP;
        end
        // Stack fault reset keeps the flags
        if (st_d.rst_out) begin
            st_d.pc = PC_RESET;
            st_d.sp = SP_EMPTY;
            st_d.phase = PHASE_Q1;
        end
    end

    // State register
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= '0;
            st_q.sp <= SP_EMPTY;
            st_q.opt <= OPT_RESET;
            st_q.pc <= PC_RESET;
            st_q.lath <= LATCH_RESET;
            st_q.phase <= PHASE_Q1;
            st_q.ready <= 1'b1;
            st_q.addr <= OFF_UNMAPPED;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign HRDATA = st_q.rdata;
    assign HREADYOUT = st_q.ready;
    assign HRESP = st_q.resp;
    assign PC_OUT = st_q.pc;
    assign PHASE = st_q.phase;
    assign STACK_RESET = st_q.rst_out;
    assign RESTORE_VALID = st_q.rvalid;
    assign RESTORE_STATUS = st_q.sh_status;
    assign RESTORE_WORK = st_q.sh_work;
    assign RESTORE_BANK = st_q.sh_bank;

    // Checks on the stack, program counter, phase ring, shadow and bus wait state
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);

    AST_PUSH_STORE: assert property (
        CMD_VALID && (cmd == CMD_PUSH || cmd == CMD_CALL) && !st_q.pend && st_q.sp < SP_LAST
        |=> st_q.sp == $past(st_q.sp) + SP_ONE && st_q.stk[st_q.sp - SP_ONE] == $past(st_q.pc))
        else $error("push did not store pc at new top");
    AST_RET_LOAD: assert property (
        CMD_VALID && cmd == CMD_RETURN && !st_q.pend && st_q.sp != SP_EMPTY
        |=> st_q.pc == $past(top_q) && st_q.sp == $past(st_q.sp) - SP_ONE)
        else $error("return did not load top and decrement");
    AST_FULL_HOLD: assert property (
        CMD_VALID && cmd == CMD_PUSH && !st_q.pend && !st_q.opt && st_q.sp == SP_TOP
        |=> st_q.sp == SP_TOP && st_q.full && $stable(st_q.stk))
        else $error("push beyond full changed the stack");
    AST_OVF_RESET: assert property (
        CMD_VALID && cmd == CMD_PUSH && !st_q.pend && st_q.opt && st_q.sp == SP_LAST
        |=> STACK_RESET && st_q.sp == SP_EMPTY && st_q.full && st_q.stk[SP_LAST] == $past(st_q.pc) + PC_STEP)
        else $error("overflow reset sequence wrong");
    AST_UNDERFLOW: assert property (
        CMD_VALID && cmd == CMD_RETURN && !st_q.pend && !st_q.opt && st_q.sp == SP_EMPTY
        |=> st_q.unf && st_q.sp == SP_EMPTY && !STACK_RESET ##1 st_q.unf)
        else $error("underflow not flagged");
    AST_LATCH_KEEP: assert property (
        CMD_VALID && (cmd == CMD_CALL || cmd == CMD_RETURN) && !st_q.pend
        |=> $stable(st_q.lath) && $stable(st_q.latu))
        else $error("holding latch changed by call or return");
    AST_PC_STEP: assert property (
        !CMD_VALID && !st_q.pend && st_q.phase == PHASE_Q1
        |=> st_q.pc == $past(st_q.pc) + PC_STEP && !st_q.pc[0])
        else $error("pc did not step by two in q1");
    // Quiet cycles outside Q1 leave the program counter alone
    AST_PC_HOLD: assert property (
        !CMD_VALID && !st_q.pend && st_q.phase != PHASE_Q1 |=> $stable(st_q.pc))
        else $error("pc moved outside q1");
    // Ring rotates every edge unless a stack fault restarts it
    AST_PHASE_RING: assert property (
        !st_d.rst_out |=> PHASE == {$past(PHASE[2:0]), $past(PHASE[3])})
        else $error("phase ring out of order");
    AST_SHADOW: assert property (
        CMD_VALID && cmd == CMD_INT_ACK |=> RESTORE_STATUS == $past(STATUS_IN) && RESTORE_BANK == $past(BANK_IN))
        else $error("shadow not loaded on interrupt");
    AST_BUS_WAIT: assert property (
        HSEL && HTRANS[1] && HREADY && HREADYOUT && !st_q.pend |=> !HREADYOUT ##1 HREADYOUT)
        else $error("bus answer not after one wait state");

endmodule // pc_and_return_stack_unit
`default_nettype wire

// >>> pcstack_pkg.sv
// Constants, register map and command codes of the program counter and return stack unit
package pcstack_pkg;
    localparam int STACK_DEPTH = 31;
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    // Pointer landmarks
    localparam logic [4:0] SP_EMPTY = 5'h00;
    localparam logic [4:0] SP_LAST = 5'h1e;
    localparam logic [4:0] SP_TOP = 5'h1f;
    localparam logic [4:0] SP_ONE = 5'h01;
    // Program counter step and vectors
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [20:0] PC_RESET = 21'h000000;
    // Phase ring, one-hot Q1..Q4
    localparam logic [3:0] PHASE_Q1 = 4'h1;
    // Register byte offsets
    localparam logic [7:0] OFF_STACK_PTR = 8'h00;
    localparam logic [7:0] OFF_TOP_LOW = 8'h04;
    localparam logic [7:0] OFF_TOP_HIGH = 8'h08;
    localparam logic [7:0] OFF_TOP_UPPER = 8'h0c;
    localparam logic [7:0] OFF_PC_LOW = 8'h10;
    localparam logic [7:0] OFF_PC_HIGH_LAT = 8'h14;
    localparam logic [7:0] OFF_PC_UPPER_LAT = 8'h18;
    localparam logic [7:0] OFF_CONTROL = 8'h1c;
    localparam logic [7:0] OFF_UNMAPPED = 8'hff;
    // Field positions in the stack pointer and control registers
    localparam int FULL_BIT = 7;
    localparam int UNF_BIT = 6;
    localparam int RSVD_BIT = 5;
    localparam int OPT_BIT = 0;
    // Values after reset
    localparam logic OPT_RESET = 1'b1;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    // Commands from the decoder and interrupt logic
    typedef enum logic [3:0] {
        CMD_CALL,
        CMD_CALL_FAST,
        CMD_INT_ACK,
        CMD_RETURN,
        CMD_RETURN_FAST,
        CMD_RET_LIT,
        CMD_RET_INT,
        CMD_RET_INT_FAST,
        CMD_PUSH,
        CMD_POP,
        CMD_JUMP
    } cmd_e;
endpackage

// >>> decode_model.sv
// Model of the instruction decoder and interrupt logic that issues stack commands
`timescale 1ns/1ps
`default_nettype none
module decode_model
    import pcstack_pkg::*;
(
    // Clock
    input wire logic CLOCK,
    // Commands
    output logic CMD_VALID,
    output logic [3:0] CMD,
    output logic [20:0] TARGET,
    // Working registers offered to the shadow
    output logic [7:0] STATUS_IN,
    output logic [7:0] WORK_IN,
    output logic [7:0] BANK_IN
);
    // Idle values at time zero
    initial begin
        CMD_VALID = 1'b0;
        CMD = 4'h0;
        TARGET = 21'h000000;
        {STATUS_IN, WORK_IN, BANK_IN} = 24'h000000;
    end
    // Hold one command up to the coming edge; calls may follow back to back
    task automatic issue(input cmd_e c, input logic [20:0] t);
        CMD_VALID <= 1'b1;
        CMD <= c;
        TARGET <= t;
        @(posedge CLOCK);
    endtask
    // Drop the strobe; code and target stop showing their last values
    task automatic rel();
        CMD_VALID <= 1'b0;
        CMD <= ~CMD;
        TARGET <= ~TARGET;
    endtask
    // Present status, working and bank values
    task automatic regs(input logic [23:0] v);
        {STATUS_IN, WORK_IN, BANK_IN} <= v;
    endtask
endmodule // decode_model
`default_nettype wire

// >>> pc_and_return_stack_unit_tb.sv
// Self-checking testbench of the program counter and return stack unit
`timescale 1ns/1ps
`default_nettype none
module pc_and_return_stack_unit_tb;
    import pcstack_pkg::*;
    typedef struct packed {cmd_e p; cmd_e q; logic f;} row_s;
    logic clock, reset_n, hsel, hwrite, hreadyout, hresp, cmd_valid;
    logic stack_reset, restore_valid;
    logic [31:0] haddr, hwdata, hrdata, rd, v;
    logic [1:0] htrans;
    logic [3:0] cmd, phase;
    logic [20:0] target, pc_out, a, t;
    logic [7:0] st, wk, bk, rs_status, rs_work, rs_bank;
    int err_total, num_checks;
    // Call kind, return kind, fast restore expected
    row_s rows [5] = '{'{CMD_CALL, CMD_RETURN, 1'b0}, '{CMD_CALL_FAST, CMD_RETURN_FAST, 1'b1},
        '{CMD_INT_ACK, CMD_RET_INT_FAST, 1'b1}, '{CMD_CALL, CMD_RET_LIT, 1'b0},
        '{CMD_INT_ACK, CMD_RET_INT, 1'b0}};

    pc_and_return_stack_unit dut (
        .CLOCK(clock), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .CMD_VALID(cmd_valid), .CMD(cmd), .TARGET(target),
        .STATUS_IN(st), .WORK_IN(wk), .BANK_IN(bk), .PC_OUT(pc_out), .PHASE(phase),
        .STACK_RESET(stack_reset), .RESTORE_VALID(restore_valid), .RESTORE_STATUS(rs_status),
        .RESTORE_WORK(rs_work), .RESTORE_BANK(rs_bank)
    );
    decode_model dec (
        .CLOCK(clock), .CMD_VALID(cmd_valid), .CMD(cmd), .TARGET(target),
        .STATUS_IN(st), .WORK_IN(wk), .BANK_IN(bk)
    );

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tmo();
        err_total++;
        $display("[FAIL] %0t wait limit reached", $time);
        results();
    endtask
    // One AHB-Lite single word transfer, waits on ready in both phases
    task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, ad};
        hwrite <= w;
        do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) tmo();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40) tmo();
        rd = hrdata;
        chk(hresp, 32'h0);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus(ad, 1'b1, d);
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
        bus(ad, 1'b0, 32'h0);
        chk(rd, e);
    endtask
    // Wait a few edges for a stack reset or restore pulse
    task automatic pulse(input bit r);
        int n;
        n = 0;
        do begin @(posedge clock); n++; end while ((r ? restore_valid : stack_reset) !== 1'b1 && n < 5);
        if ((r ? restore_valid : stack_reset) !== 1'b1) tmo();
    endtask
    task automatic rst();
        reset_n <= 1'b0;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
    endtask

    // Main sequence
    initial begin
        {hsel, hwrite, reset_n} = 3'h0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        err_total = 0;
        num_checks = 0;
        rst();
        #1 chk(pc_out, 32'(PC_STEP));
        rchk(OFF_STACK_PTR, 32'h0);
        rchk(OFF_CONTROL, 32'h1);
        // Phase ring and sequential step
        for (int k = 0; k < 4; k++) begin
            #1;
            a = {17'h0, phase};
            @(posedge clock);
            #1 chk(phase, {a[2:0], a[3]});
        end
        a = pc_out;
        repeat (4) @(posedge clock);
        #1 chk(pc_out, a + PC_STEP);
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_PC_HIGH_LAT, 32'h5a);
        wr(OFF_PC_UPPER_LAT, 32'h03);
        // Call kinds paired with return kinds
        for (int i = 0; i < 5; i++) begin
            a = 21'h001040 + 21'(i) * 21'h000100;
            t = a + 21'h010000;
            dec.regs(24'h102030 + 24'(i));
            dec.issue(CMD_JUMP, a);
            dec.issue(rows[i].p, t);
            dec.rel();
            #1 chk(pc_out, t);
            dec.regs(24'hffffff);
            rchk(OFF_STACK_PTR, 32'h1);
            rchk(OFF_TOP_LOW, a[7:0]);
            rchk(OFF_TOP_HIGH, a[15:8]);
            dec.issue(rows[i].q, 21'h0);
            dec.rel();
            #1 chk(pc_out, a);
            if (rows[i].f) begin
                pulse(1'b1);
                chk({rs_status, rs_work, rs_bank}, 24'h102030 + 24'(i));
            end
            rchk(OFF_STACK_PTR, 32'h0);
        end
        rchk(OFF_PC_HIGH_LAT, 32'h5a);
        rchk(OFF_PC_UPPER_LAT, 32'h03);
        // Push, top writes, pop, pointer written by software
        wr(OFF_STACK_PTR, 32'h3);
        dec.issue(CMD_JUMP, 21'h00abc0);
        dec.issue(CMD_PUSH, 21'h0);
        dec.rel();
        #1 chk(pc_out, 32'habc0);
        rchk(OFF_STACK_PTR, 32'h4);
        rchk(OFF_TOP_LOW, 32'hc0);
        wr(OFF_TOP_LOW, 32'h22);
        wr(OFF_TOP_HIGH, 32'h33);
        wr(OFF_TOP_UPPER, 32'h04);
        rchk(OFF_TOP_UPPER, 32'h04);
        dec.issue(CMD_POP, 21'h0);
        dec.rel();
        rchk(OFF_STACK_PTR, 32'h3);
        wr(OFF_STACK_PTR, 32'h4);
        dec.issue(CMD_RETURN, 21'h0);
        dec.rel();
        #1 chk(pc_out, 32'h043322);
        // Low byte write and read against the holding latches
        dec.issue(CMD_JUMP, 21'h000101);
        dec.rel();
        #1 chk(pc_out, 32'h100);
        wr(OFF_PC_HIGH_LAT, 32'h12);
        wr(OFF_PC_UPPER_LAT, 32'h03);
        wr(OFF_PC_LOW, 32'h35);
        #1 chk(pc_out, 32'h031234 + ((phase == 4'h2) ? 32'h2 : 32'h0));
        wr(OFF_PC_HIGH_LAT, 32'h0);
        wr(OFF_PC_UPPER_LAT, 32'h0);
        bus(OFF_PC_LOW, 1'b0, 32'h0);
        rchk(OFF_PC_HIGH_LAT, 32'h12);
        rchk(OFF_PC_UPPER_LAT, 32'h03);
        // Full stack with the reset option off
        wr(OFF_STACK_PTR, 32'h0);
        repeat (31) dec.issue(CMD_PUSH, 21'h0);
        dec.rel();
        rchk(OFF_STACK_PTR, 32'h9f);
        bus(OFF_TOP_HIGH, 1'b0, 32'h0);
        v = rd;
        dec.issue(CMD_JUMP, 21'h1fff00);
        dec.issue(CMD_PUSH, 21'h0);
        dec.rel();
        rchk(OFF_STACK_PTR, 32'h9f);
        rchk(OFF_TOP_HIGH, v);
        wr(OFF_STACK_PTR, 32'h1f);
        rchk(OFF_STACK_PTR, 32'h1f);
        // Underflow with the reset option off
        wr(OFF_STACK_PTR, 32'h0);
        dec.issue(CMD_RETURN, 21'h0);
        dec.rel();
        #1 chk(pc_out, 32'h0);
        rchk(OFF_STACK_PTR, 32'h40);
        wr(OFF_STACK_PTR, 32'h20);
        rchk(OFF_STACK_PTR, 32'h0);
        wr(8'h20, 32'hffffffff);
        rchk(8'h20, 32'h0);
        // Overflow and underflow resets with the option on
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_STACK_PTR, 32'h1e);
        dec.issue(CMD_JUMP, 21'h0abcd4);
        dec.issue(CMD_PUSH, 21'h0);
        dec.rel();
        pulse(1'b0);
        rchk(OFF_STACK_PTR, 32'h80);
        wr(OFF_STACK_PTR, 32'h9f);
        rchk(OFF_TOP_UPPER, 32'h0a);
        rchk(OFF_TOP_LOW, 32'hd6);
        wr(OFF_STACK_PTR, 32'h0);
        dec.issue(CMD_POP, 21'h0);
        dec.rel();
        pulse(1'b0);
        rchk(OFF_STACK_PTR, 32'h40);
        // Reset in mid-run clears pointer and flags
        rst();
        rchk(OFF_STACK_PTR, 32'h0);
        results();
    end
endmodule // pc_and_return_stack_unit_tb
`default_nettype wire
